// *** hw/sar_adc_consts.vh ***
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH
`define RESULT_WIDTH      12
`define BUS_WIDTH         8
`define CLK_PERIOD_NS     8
`define CONVERT_PULSE_NS  40
`define CONVERT_PULSE_CYC ((`CONVERT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONVERT_TIME_NS   14700
`define CONVERT_TIME_CYC  (`CONVERT_TIME_NS / `CLK_PERIOD_NS)
`define SCLK_PERIOD_NS    1104
`define SCLK_HALF_CYC     ((`SCLK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define SCLK_START_NS     1400
`define SCLK_START_CYC    (`SCLK_START_NS / `CLK_PERIOD_NS)
`define MIDSCALE_FLIP     12'h800
`define CODE_POS_FS_BTC   12'h7FF
`define CODE_NEG_FS_BTC   12'h800
`endif

// *** hw/sar_adc_sync.v ***
`timescale 1ns/1ps
module sar_adc_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // asynchronous in, synchronised out
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;

  // stage1 feeds syncOut only
  always @(posedge clk) begin
    if (sys_rst) begin
      stage1  <= {WIDTH{1'b1}};
      syncOut <= {WIDTH{1'b1}};
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // sar_adc_sync

// *** hw/sar_adc_control.v ***
// Function
// - both selects low for the minimum pulse width holds the sample and starts conversion
// - busy goes low at start and stays low until the result register updates
// - convert commands are ignored while busy is low
// - selects still low when busy rises start a new, invalid conversion
// - chip select high: no operation and parallel bus high impedance
// - any conversion start leaves or puts the parallel bus high impedance
// - select low, read high, busy high drives the latest completed result
// - bus enabled while busy low shows the previous conversion result
// - chip select and read/convert combine as a level sensitive OR
// - internal clock mode drives bit clock and shifts previous result after start
// - chip select tied low lets read/convert alone control convert and reads, except external clock reads, which need chip select to fall
// - format select high gives straight binary, low gives two's complement
// - codes: two's complement 7FF/000/800, straight binary FFF/800/000
// - parallel read keeps the output register, serial read shifts a copy of it per pulse
// - external clock mode takes bit clock as input, conversion still internal
// - external clock mode shifts result out in step with the external clock
// - internal mode: twelve bits msb first, then clock low and tail level out
// - byte select low: top eight bits; high: low four bits on upper pins
// - parallel pins driven only with read high and chip select low
`timescale 1ns/1ps
`include "sar_adc_consts.vh"
module sar_adc_control #(
  parameter WIDTH      = `RESULT_WIDTH,
  parameter CONV_CYC   = `CONVERT_TIME_CYC,
  parameter PULSE_CYC  = `CONVERT_PULSE_CYC,
  parameter HALF_CYC   = `SCLK_HALF_CYC,
  parameter START_CYC  = `SCLK_START_CYC
) (
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // host control pins, active low selects
  input  wire             chipSel_n,
  input  wire             readConvert,
  input  wire             byteSelect,
  input  wire             output_format_select,
  input  wire             data_clock_source_select,
  input  wire             serialTag,
  // sampled value from the analog core, straight binary
  input  wire [WIDTH-1:0] sampleCode,
  // status
  output reg              busy_n,
  output reg              invalidSample,
  // parallel bus, enable low while driving
  output reg  [`BUS_WIDTH-1:0] parallel_data_pins,
  output reg              parallelOe_n,
  // serial data and bit clock pin
  input  wire             serialClkIn,
  output reg              serial_bit_clock,
  output reg              serialClkOe_n,
  output reg              serial_out_line
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ARM  = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  wire [2:0] syncPins;
  wire       csSync;
  wire       rcSync;
  wire       extClkSync;

  sar_adc_sync #(.WIDTH(3)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({chipSel_n, readConvert, serialClkIn}),
    .syncOut (syncPins)
  );
  assign csSync     = syncPins[2];
  assign rcSync     = syncPins[1];
  assign extClkSync = syncPins[0];

  // format conversion: two's complement flips the top bit
  function [WIDTH-1:0] formatCode;
    input [WIDTH-1:0] code;
    input             straight;
    begin
      formatCode = straight ? code : (code ^ `MIDSCALE_FLIP);
    end
  endfunction

  reg  [2:0]       state;
  reg  [15:0]      pulseCnt;
  reg  [31:0]      convCnt;
  reg  [WIDTH-1:0] holdCode;
  reg  [WIDTH-1:0] outReg;
  reg  [WIDTH-1:0] shiftReg;
  reg              prevCs;
  reg              prevRc;
  reg              prevExtClk;
  reg              sampled;
  reg  [15:0]      sclkDiv;
  reg  [4:0]       sclkEdges;
  reg              sclkRun;
  reg  [15:0]      sclkDelay;
  reg              tailLevel;
  reg              extShiftEn;

  // level-sensitive OR of the two active-low controls
  wire convLevel = ~csSync & ~rcSync;
  wire busEnable = ~csSync & rcSync;
  wire extRise   = extClkSync & ~prevExtClk;
  wire csFall    = ~csSync & prevCs;

  always @(posedge clk) begin
    if (sys_rst) begin
      state         <= ST_IDLE;
      pulseCnt      <= 16'h0000;
      convCnt       <= 32'h0000_0000;
      holdCode      <= {WIDTH{1'b0}};
      outReg        <= {WIDTH{1'b0}};
      busy_n        <= 1'b1;
      invalidSample <= 1'b0;
      sampled       <= 1'b0;
      prevCs        <= 1'b1;
      prevRc        <= 1'b1;
      prevExtClk    <= 1'b0;
      extShiftEn    <= 1'b0;
    end else begin
      prevCs     <= csSync;
      prevRc     <= rcSync;
      prevExtClk <= extClkSync;
      case (state)
        ST_IDLE: begin
          pulseCnt <= 16'h0000;
          if (convLevel) begin
            state <= ST_ARM;
          end
        end
        ST_ARM: begin
          if (!convLevel) begin
            state <= ST_IDLE; // pulse too short is dropped
          end else if (pulseCnt >= PULSE_CYC[15:0] - 16'h0002) begin
            state    <= ST_CONV;
            busy_n   <= 1'b0;
            convCnt  <= 32'h0000_0000;
            holdCode <= sampleCode;
            invalidSample <= ~sampled;
          end else begin
            pulseCnt <= pulseCnt + 16'h0001;
          end
        end
        ST_CONV: begin
          // selects are not looked at here: commands ignored while busy
          if (convCnt == CONV_CYC - 1) begin
            outReg <= formatCode(holdCode, output_format_select);
            busy_n <= 1'b1;
            sampled <= 1'b0;
            // selects still low here re-arm from idle with no acquisition,
            // so busy is seen to rise before the invalid restart
            state <= ST_IDLE;
          end else begin
            convCnt <= convCnt + 32'h0000_0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (state == ST_IDLE && !convLevel) begin
        sampled <= 1'b1; // tracking between conversions
      end
      // external clock shifting: armed by chip select falling while read high
      if (csSync || !rcSync) begin
        extShiftEn <= 1'b0;
      end else if (csFall && rcSync) begin
        extShiftEn <= 1'b1;
      end
    end
  end

  // serial shift register and internal bit clock
  wire [WIDTH-1:0] loadValue = outReg;
  always @(posedge clk) begin
    if (sys_rst) begin
      shiftReg         <= {WIDTH{1'b0}};
      sclkDiv          <= 16'h0000;
      sclkEdges        <= 5'h00;
      sclkRun          <= 1'b0;
      sclkDelay        <= 16'h0000;
      serial_bit_clock <= 1'b0;
      serialClkOe_n    <= 1'b1;
      serial_out_line  <= 1'b0;
      tailLevel        <= 1'b0;
    end else begin
      serialClkOe_n <= data_clock_source_select;
      if (!data_clock_source_select && state == ST_ARM && busy_n &&
          pulseCnt >= PULSE_CYC[15:0] - 16'h0002 && convLevel) begin
        shiftReg  <= loadValue; // previous result into shifter
        sclkDelay <= START_CYC[15:0];
        sclkRun   <= 1'b1;
        sclkDiv   <= 16'h0000;
        sclkEdges <= 5'h00;
        serial_bit_clock <= 1'b0;
        serial_out_line  <= loadValue[WIDTH-1];
      end else if (sclkRun) begin
        if (sclkDelay != 16'h0000) begin
          sclkDelay <= sclkDelay - 16'h0001;
        end else if (sclkDiv == HALF_CYC[15:0] - 16'h0001) begin
          sclkDiv <= 16'h0000;
          serial_bit_clock <= ~serial_bit_clock;
          if (!serial_bit_clock) begin
            if (sclkEdges == 5'h00) begin
              tailLevel <= serialTag;
            end
          end else begin
            // falling edge: advance to the next bit
            shiftReg  <= {shiftReg[WIDTH-2:0], 1'b0};
            sclkEdges <= sclkEdges + 5'h01;
            if (sclkEdges == WIDTH - 1) begin
              sclkRun <= 1'b0;
              serial_out_line <= tailLevel;
            end else begin
              serial_out_line <= shiftReg[WIDTH-2];
            end
          end
        end else begin
          sclkDiv <= sclkDiv + 16'h0001;
        end
      end else if (data_clock_source_select) begin
        serial_bit_clock <= 1'b0;
        if (csFall && rcSync) begin
          shiftReg        <= outReg; // n if busy high, n-1 if low
          serial_out_line <= outReg[WIDTH-1];
        end else if (extShiftEn && extRise) begin
          shiftReg        <= {shiftReg[WIDTH-2:0], serialTag};
          serial_out_line <= shiftReg[WIDTH-2];
        end
      end
    end
  end

  // parallel bus: reads never disturb outReg
  always @(posedge clk) begin
    if (sys_rst) begin
      parallel_data_pins <= {`BUS_WIDTH{1'b0}};
      parallelOe_n       <= 1'b1;
    end else begin
      parallelOe_n <= ~busEnable;
      if (!byteSelect) begin
        parallel_data_pins <= outReg[WIDTH-1:WIDTH-`BUS_WIDTH];
      end else begin
        parallel_data_pins <= {outReg[3:0], 4'h0};
      end
    end
  end
endmodule // sar_adc_control

// *** tb/sar_adc_checker_properties.sv ***
`timescale 1ns/1ps
module sar_adc_checker #(
  parameter CONV_CYC = 80
) (
  // clock and reset
  input wire       clk,
  input wire       sys_rst,
  // host pins
  input wire       chipSel_n,
  input wire       readConvert,
  input wire       byteSelect,
  input wire       data_clock_source_select,
  // device outputs
  input wire       busy_n,
  input wire       invalidSample,
  input wire [7:0] parallel_data_pins,
  input wire       parallelOe_n,
  input wire       serial_bit_clock,
  input wire       serialClkOe_n
);
  integer lowCnt;
  always @(posedge clk) lowCnt <= (sys_rst || busy_n) ? 0 : lowCnt + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  busy_len_a: assert property ($rose(busy_n) |-> lowCnt == CONV_CYC)
    else $error("busy low length wrong");
  cmd_ignored_a: assert property (!busy_n && lowCnt < CONV_CYC - 1 |=> !busy_n)
    else $error("busy ended early");
  restart_a: assert property (!busy_n && lowCnt == CONV_CYC - 1 && !chipSel_n && !readConvert
    && $past(!chipSel_n && !readConvert, 8) |-> ##[1:12] (!busy_n && invalidSample))
    else $error("no invalid restart");
  cs_idle_a: assert property (chipSel_n [*5] |-> parallelOe_n)
    else $error("bus driven with select high");
  conv_tri_a: assert property (!readConvert [*5] |-> parallelOe_n)
    else $error("bus driven while converting");
  read_drive_a: assert property ((!chipSel_n && readConvert) [*5] |-> !parallelOe_n)
    else $error("bus not driven on read");
  lsb_zero_a: assert property (!parallelOe_n && byteSelect && $past(byteSelect)
    && $past(byteSelect, 2) |-> parallel_data_pins[3:0] == 4'h0)
    else $error("low pins not zero");
  ext_clk_a: assert property (data_clock_source_select [*3] |-> serialClkOe_n)
    else $error("bit clock driven in external mode");
  idle_clk_a: assert property (busy_n && $past(busy_n) |-> !serial_bit_clock)
    else $error("bit clock not idle low");
endmodule // sar_adc_checker
bind sar_adc_control sar_adc_checker #(.CONV_CYC(CONV_CYC)) chk (
  .clk(clk), .sys_rst(sys_rst), .chipSel_n(chipSel_n), .readConvert(readConvert),
  .byteSelect(byteSelect), .data_clock_source_select(data_clock_source_select),
  .busy_n(busy_n), .invalidSample(invalidSample), .parallel_data_pins(parallel_data_pins),
  .parallelOe_n(parallelOe_n), .serial_bit_clock(serial_bit_clock),
  .serialClkOe_n(serialClkOe_n));

// *** tb/host_link_model.sv ***
`timescale 1ns/1ps
// host bit clock, 125 ns period; stands still low outside a read frame
module host_link_model (
  // frame control
  input wire run,
  // clock to the device
  output reg linkClk
);
  initial linkClk = 1'h0;
  always begin
    #62.5;
    linkClk = run ? ~linkClk : 1'h0;
  end
endmodule // host_link_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  reg        clk = 1'h0, sys_rst = 1'h1, chipSel_n = 1'h1, readConvert = 1'h1;
  reg        byteSelect = 1'h0, fmt = 1'h0, extSel = 1'h0, serialTag = 1'h1, runClk = 1'h0;
  reg [11:0] sampleCode = 12'h000, code, exp, bits;
  integer    i, k, pulses, failures = 0, compares = 0;
  wire       busy_n, invalidSample, parallelOe_n, sbc, sclkOe_n, sout, linkClk;
  wire [7:0] pins;
  always #4 clk = ~clk;
  always @(posedge sbc) begin
    bits <= {bits[10:0], sout};
    pulses <= pulses + 1;
  end
  host_link_model host (.run(runClk), .linkClk(linkClk));
  sar_adc_control #(.CONV_CYC(80), .HALF_CYC(2), .START_CYC(3)) dut (
    .clk(clk), .sys_rst(sys_rst), .chipSel_n(chipSel_n), .readConvert(readConvert),
    .byteSelect(byteSelect), .output_format_select(fmt), .data_clock_source_select(extSel),
    .serialTag(serialTag), .sampleCode(sampleCode), .busy_n(busy_n),
    .invalidSample(invalidSample), .parallel_data_pins(pins), .parallelOe_n(parallelOe_n),
    .serialClkIn(linkClk), .serial_bit_clock(sbc), .serialClkOe_n(sclkOe_n),
    .serial_out_line(sout));
  task chk(input [11:0] got, input [11:0] want);
    begin
      compares = compares + 1;
      if (got !== want) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
    end
  endtask
  task end_sim;
    begin
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task waitBusy(input lvl);
    integer n;
    begin
      n = 0;
      while (busy_n !== lvl && n < 400) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk(busy_n, lvl);
      @(posedge clk);
    end
  endtask
  // read/convert leads chip select by two cycles so chip select triggers
  task convert(input [11:0] c);
    begin
      sampleCode <= c;
      readConvert <= 1'h0;
      repeat (2) @(posedge clk);
      chipSel_n <= 1'h0;
      repeat (10) @(posedge clk);
      chipSel_n <= 1'h1;
      readConvert <= 1'h1;
      waitBusy(1'h0);
    end
  endtask
  task readByte(input bs, input [7:0] want);
    begin
      byteSelect <= bs;
      chipSel_n <= 1'h0;
      repeat (6) @(posedge clk);
      #1;
      chk(parallelOe_n, 1'h0);
      chk(pins, want);
      @(posedge clk);
      chipSel_n <= 1'h1;
      @(posedge clk);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    for (i = 0; i < 6; i = i + 1) begin
      fmt <= i[0];
      code = (i < 2) ? 12'hFFF : (i < 4) ? 12'h800 : 12'h000;
      convert(code);
      waitBusy(1'h1);
      repeat (2) @(posedge clk);
      exp = i[0] ? code : code ^ 12'h800;
      readByte(1'h0, exp[11:4]);
      readByte(1'h1, {exp[3:0], 4'h0});
      readByte(1'h0, exp[11:4]);
    end
    convert(12'hA5C);
    waitBusy(1'h1);
    convert(12'h3C1);
    readByte(1'h0, 8'hA5);
    convert(12'h777);
    waitBusy(1'h1);
    readByte(1'h0, 8'h3C);
    chk(invalidSample, 1'h0);
    readConvert <= 1'h0;
    chipSel_n <= 1'h0;
    repeat (100) @(posedge clk);
    #1;
    chk(busy_n, 1'h0);
    chk(invalidSample, 1'h1);
    @(posedge clk);
    chipSel_n <= 1'h1;
    readConvert <= 1'h1;
    waitBusy(1'h1);
    convert(12'h3C1);
    waitBusy(1'h1);
    pulses = 0;
    code = 12'h9A6;
    convert(code);
    waitBusy(1'h1);
    chk(pulses, 12);
    chk(bits, 12'h3C1);
    chk(sout, 1'h1);
    extSel <= 1'h1;
    chipSel_n <= 1'h0;
    repeat (6) @(posedge clk);
    #1;
    chk(sout, code[11]);
    runClk = 1'h1;
    for (k = 10; k >= 0; k = k - 1) begin
      @(negedge linkClk);
      chk(sout, code[k]);
    end
    runClk = 1'h0;
    @(posedge clk);
    chipSel_n <= 1'h1;
    repeat (10) @(posedge clk);
    end_sim;
  end
  initial begin
    #100000;
    failures = failures + 1;
    end_sim;
  end
endmodule // tb
